// [logic/tpc_timer.sv]
`timescale 1ns/100ps
// Behaviour
// - edge pwm on up counter beside other modes
// - edge period modulus plus one, width to match
// - edge polarity: overflow sets, match clears, invertible
// - zero value gives zero duty edge pwm
// - value above modulus gives full duty
// - value buffered, loads at modulus step
// - center width twice value, period twice modulus
// - center counter up to modulus, down to zero
// - center zero or negative value gives zero duty
// - center match up low, down high
// - center select makes every channel with an edge bit set center pwm
// - center modulus and value writes are buffered
// - center overflow raised at end of modulus count
// - control writes discard pending byte writes
// - every system reset resets the block
// - reset clears counter, modulus, channel values, flags and pins
// - channel flag set on capture edge or match
// - overflow flag on terminal count, its interrupt gated by enable
// - channel flag has own interrupt enable
// - interrupt outputs active high
// - set wins over flag clear
// - clock code zero stops counter, keeps contents
// - up counter wraps at modulus or max
module tpc_timer #(
    parameter int NUM_CH = tpc_pkg::NUM_CH_DEF
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [1:0]        clock_source_select_i,
    input  wire logic              fixed_clk_en_i,
    input  wire logic              ext_clk_i,
    input  wire logic              center_align_select_i,
    input  wire logic              overflow_irq_enable_i,
    input  wire logic              tsc_write_i,
    input  wire logic              mod_lo_wr_i,
    input  wire logic              mod_hi_wr_i,
    input  wire logic              cnt_write_i,
    input  wire logic [7:0]        wr_data_i,
    input  wire logic              overflow_clear_i,
    input  wire logic [NUM_CH-1:0] channel_mode_sel_a_i,
    input  wire logic [NUM_CH-1:0] channel_mode_sel_b_i,
    input  wire logic [NUM_CH-1:0] edge_level_sel_a_i,
    input  wire logic [NUM_CH-1:0] edge_level_sel_b_i,
    input  wire logic [NUM_CH-1:0] channel_irq_enable_i,
    input  wire logic [NUM_CH-1:0] csc_write_i,
    input  wire logic [NUM_CH-1:0] val_lo_wr_i,
    input  wire logic [NUM_CH-1:0] val_hi_wr_i,
    input  wire logic [NUM_CH-1:0] flag_clear_i,
    input  wire logic [NUM_CH-1:0] capture_pin_i,
    output logic      [15:0]       counter_value_o,
    output logic      [15:0]       modulus_value_o,
    output logic                   overflow_flag_o,
    output logic                   overflow_irq_o,
    output logic      [NUM_CH-1:0] channel_event_flag_o,
    output logic      [NUM_CH-1:0] channel_irq_o,
    output logic      [NUM_CH-1:0] pin_o,
    output logic      [NUM_CH-1:0] pin_oe_o,
    output logic      [NUM_CH*16-1:0] channel_value_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] modv;
        logic [15:0] mod_buf;
        logic        mgot_lo;
        logic        mgot_hi;
        logic        mpend;
        logic        down;
        logic        overflow_flag;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_prev;
    } tpc_tmr_st_t;

    tpc_tmr_st_t s_q;
    tpc_tmr_st_t s_d;

    logic        tick;
    logic        clk_off;
    logic        ovf;
    logic        load_point;
    logic [15:0] term;

    // refused at elaboration: the channel vector widths assume 1..8
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
        $error("tpc_timer: NUM_CH must be 1..8");
    end

    // terminal count: modulus, or max when modulus is zero
    function automatic logic [15:0] term_of(input logic [15:0] m);
        term_of = (m == tpc_pkg::MOD_RST) ? tpc_pkg::CNT_MAX : m;
    endfunction

    // ------------------------------------------------------------------
    // counter clock selection
    // ------------------------------------------------------------------
    assign clk_off = clock_source_select_i == tpc_pkg::CLK_OFF;
    always_comb begin
        case (clock_source_select_i)
            tpc_pkg::CLK_BUS:   tick = 1'b1;
            tpc_pkg::CLK_FIXED: tick = fixed_clk_en_i;
            // external clock sampled after two flops, rising edge counts
            tpc_pkg::CLK_EXT:   tick = s_q.ext_s2 & !s_q.ext_prev;
            default:            tick = 1'b0;
        endcase
    end

    assign term = term_of(s_q.modv);
    // edge mode wraps at terminal; center mode turns at modulus
    assign ovf  = tick & (center_align_select_i ?
                  (!s_q.down & s_q.cnt == s_q.modv)
                  : (s_q.cnt == term));
    // load when counter steps to terminal (modulus minus one to modulus)
    assign load_point = tick & (s_q.cnt == term - 16'h0001) &
                        !s_q.down;

    // ------------------------------------------------------------------
    // counter and modulus buffer
    // ------------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.ext_s1   = ext_clk_i;
        s_d.ext_s2   = s_q.ext_s1;
        s_d.ext_prev = s_q.ext_s2;
        if (tsc_write_i) begin
            s_d.mgot_lo = 1'b0;
            s_d.mgot_hi = 1'b0;
            s_d.mpend   = 1'b0;
        end else begin
            if (mod_lo_wr_i) begin
                s_d.mod_buf[7:0] = wr_data_i;
                s_d.mgot_lo      = 1'b1;
            end
            if (mod_hi_wr_i) begin
                s_d.mod_buf[15:8] = wr_data_i;
                s_d.mgot_hi       = 1'b1;
            end
            if (s_d.mgot_lo & s_d.mgot_hi) begin
                s_d.mgot_lo = 1'b0;
                s_d.mgot_hi = 1'b0;
                s_d.mpend   = 1'b1;
            end
        end
        if (s_q.mpend & (clk_off | load_point)) begin
            s_d.modv  = s_q.mod_buf;
            s_d.mpend = 1'b0;
        end
        if (cnt_write_i) begin
            s_d.cnt  = tpc_pkg::CNT_ZERO;
            s_d.down = 1'b0;
        end else if (tick) begin
            if (center_align_select_i) begin
                if (!s_q.down) begin
                    if (s_q.cnt == s_q.modv) begin
                        s_d.down = 1'b1;
                        s_d.cnt  = s_q.cnt - 16'h0001;
                    end else begin
                        s_d.cnt = s_q.cnt + 16'h0001;
                    end
                end else if (s_q.cnt == tpc_pkg::CNT_ZERO) begin
                    s_d.down = 1'b0;
                    s_d.cnt  = s_q.cnt + 16'h0001;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end else begin
                s_d.down = 1'b0;
                s_d.cnt  = (s_q.cnt == term) ? tpc_pkg::CNT_ZERO
                                             : s_q.cnt + 16'h0001;
            end
        end
        if (overflow_clear_i) begin
            s_d.overflow_flag = 1'b0;
        end
        if (ovf) begin
            s_d.overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    // value above modulus never matches, so the pin holds full duty, except in center mode with bit 15 set, which gives zero duty
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        tpc_channel u_ch (
            .clk_i                 (clk_i),
            .rst_b_i               (rst_b_i),
            .center_align_select_i (center_align_select_i),
            .channel_mode_sel_a_i  (channel_mode_sel_a_i[i]),
            .channel_mode_sel_b_i  (channel_mode_sel_b_i[i]),
            .edge_level_sel_a_i    (edge_level_sel_a_i[i]),
            .edge_level_sel_b_i    (edge_level_sel_b_i[i]),
            .channel_irq_enable_i  (channel_irq_enable_i[i]),
            .csc_write_i           (csc_write_i[i]),
            .val_lo_wr_i           (val_lo_wr_i[i]),
            .val_hi_wr_i           (val_hi_wr_i[i]),
            .wr_data_i             (wr_data_i),
            .flag_clear_i          (flag_clear_i[i]),
            .capture_pin_i         (capture_pin_i[i]),
            .clk_off_i             (clk_off),
            .tick_i                (tick),
            .load_point_i          (load_point),
            .overflow_i            (ovf),
            .count_up_i            (!s_q.down),
            .counter_i             (s_q.cnt),
            .channel_value_o       (channel_value_o[i*16 +: 16]),
            .channel_event_flag_o  (channel_event_flag_o[i]),
            .channel_irq_o         (channel_irq_o[i]),
            .pin_o                 (pin_o[i]),
            .pin_oe_o              (pin_oe_o[i])
        );
    end

    assign counter_value_o = s_q.cnt;
    assign modulus_value_o = s_q.modv;
    assign overflow_flag_o = s_q.overflow_flag;
    assign overflow_irq_o  = s_q.overflow_flag & overflow_irq_enable_i;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_stop_hold: assert property (
        (clk_off & !cnt_write_i) |=> s_q.cnt == $past(s_q.cnt))
        else $error("counter moved while stopped");
    a_up_wrap: assert property (
        (tick & !center_align_select_i & s_q.cnt == term & !cnt_write_i)
        |=> s_q.cnt == 16'h0000 && s_q.overflow_flag)
        else $error("up counter did not wrap");
    a_ctr_turn: assert property (
        (tick & center_align_select_i & !s_q.down & s_q.cnt == s_q.modv
         & s_q.modv != 16'h0000 & !cnt_write_i)
        |=> s_q.down && s_q.overflow_flag)
        else $error("center counter did not turn");
    a_ctr_bottom: assert property (
        (tick & center_align_select_i & s_q.down & s_q.cnt == 16'h0000
         & !cnt_write_i)
        |=> !s_q.down && s_q.cnt == 16'h0001)
        else $error("center counter did not turn at zero");
    a_tof_keep: assert property (
        (s_q.overflow_flag & !overflow_clear_i) |=> s_q.overflow_flag)
        else $error("overflow flag lost");
    a_mod_cancel: assert property (
        tsc_write_i |=> !s_q.mpend && !s_q.mgot_lo && !s_q.mgot_hi)
        else $error("modulus write not cancelled");
    a_mod_off_load: assert property (
        (clk_off & s_q.mpend) |=> s_q.modv == $past(s_q.mod_buf))
        else $error("modulus not loaded with clock off");
    a_mod_run_hold: assert property (
        (s_q.mpend & !clk_off & !load_point) |=> s_q.modv == $past(s_q.modv))
        else $error("modulus loaded before its load point");
    a_irq_gate: assert property (
        !overflow_irq_enable_i |-> !overflow_irq_o)
        else $error("overflow irq leaked");
    a_irq_level: assert property (
        (s_q.overflow_flag & overflow_irq_enable_i) |-> overflow_irq_o)
        else $error("overflow irq not raised high");
    c_edge_wrap: cover property (ovf & !center_align_select_i);
    c_ctr_turn: cover property (ovf & center_align_select_i);
endmodule // tpc_timer

// [logic/tpc_pkg.sv]
package tpc_pkg;
    // ------------------------------------------------------------------
    // clock source codes
    // ------------------------------------------------------------------
    localparam logic [1:0] CLK_OFF   = 2'h0;
    localparam logic [1:0] CLK_BUS   = 2'h1;
    localparam logic [1:0] CLK_FIXED = 2'h2;
    localparam logic [1:0] CLK_EXT   = 2'h3;

    // ------------------------------------------------------------------
    // values and reset defaults
    // ------------------------------------------------------------------
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] MOD_RST     = 16'h0000;
    localparam logic [15:0] VAL_RST     = 16'h0000;
    localparam int          SIGN_BIT    = 15;
    localparam int          NUM_CH_DEF  = 2;

    // channel modes from mode_sel b:a and edge_level b:a
    typedef enum logic [1:0] {
        TPC_CH_CAPT = 2'h0,
        TPC_CH_OC   = 2'h1,
        TPC_CH_EPWM = 2'h3,
        TPC_CH_CENTER_ALIGNED_PWM = 2'h2
    } tpc_chmode_t;
endpackage

// [logic/tpc_channel.sv]
`timescale 1ns/100ps
// one channel: value buffer, compare, pin, flag
module tpc_channel (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        center_align_select_i,
    input  wire logic        channel_mode_sel_a_i,
    input  wire logic        channel_mode_sel_b_i,
    input  wire logic        edge_level_sel_a_i,
    input  wire logic        edge_level_sel_b_i,
    input  wire logic        channel_irq_enable_i,
    input  wire logic        csc_write_i,
    input  wire logic        val_lo_wr_i,
    input  wire logic        val_hi_wr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        flag_clear_i,
    input  wire logic        capture_pin_i,
    input  wire logic        clk_off_i,
    input  wire logic        tick_i,
    input  wire logic        load_point_i,
    input  wire logic        overflow_i,
    input  wire logic        count_up_i,
    input  wire logic [15:0] counter_i,
    output logic      [15:0] channel_value_o,
    output logic             channel_event_flag_o,
    output logic             channel_irq_o,
    output logic             pin_o,
    output logic             pin_oe_o
);
    typedef struct packed {
        logic [15:0] val;
        logic [15:0] buf_v;
        logic        got_lo;
        logic        got_hi;
        logic        pend;
        logic        flag;
        logic        pin;
        logic        cap_s1;
        logic        cap_s2;
        logic        cap_prev;
    } tpc_ch_st_t;

    tpc_ch_st_t s_q;
    tpc_ch_st_t s_d;

    logic        match;
    logic        arrive;
    logic        bottom;
    logic        pwm_any;
    logic        oc_mode;
    logic        cap_mode;
    logic        edge_hit;
    logic        center_aligned_pwm_off;

    // center mode forces every enabled channel to center pwm
    assign pwm_any  = center_align_select_i &
                      (edge_level_sel_a_i | edge_level_sel_b_i);
    assign oc_mode  = !center_align_select_i & !channel_mode_sel_b_i &
                      channel_mode_sel_a_i;
    assign cap_mode = !center_align_select_i & !channel_mode_sel_b_i &
                      !channel_mode_sel_a_i;
    assign match    = tick_i & (counter_i == s_q.val);
    // edge pulse ends as the count arrives at the value, not as it leaves
    assign arrive   = tick_i & !overflow_i &
                      (counter_i == s_q.val - 16'h0001);
    assign bottom   = tick_i & !count_up_i &
                      (counter_i == tpc_pkg::CNT_ZERO);
    assign center_aligned_pwm_off = (s_q.val == tpc_pkg::VAL_RST) |
                      s_q.val[tpc_pkg::SIGN_BIT];
    assign edge_hit = cap_mode & (s_q.cap_s2 != s_q.cap_prev) &
                      ((edge_level_sel_a_i & s_q.cap_s2) |
                       (edge_level_sel_b_i & !s_q.cap_s2));

    always_comb begin
        s_d          = s_q;
        s_d.cap_s1   = capture_pin_i;
        s_d.cap_s2   = s_q.cap_s1;
        s_d.cap_prev = s_q.cap_s2;
        if (csc_write_i) begin
            s_d.got_lo = 1'b0;
            s_d.got_hi = 1'b0;
            s_d.pend   = 1'b0;
        end else begin
            if (val_lo_wr_i) begin
                s_d.buf_v[7:0] = wr_data_i;
                s_d.got_lo     = 1'b1;
            end
            if (val_hi_wr_i) begin
                s_d.buf_v[15:8] = wr_data_i;
                s_d.got_hi      = 1'b1;
            end
            if (s_d.got_lo & s_d.got_hi) begin
                s_d.got_lo = 1'b0;
                s_d.got_hi = 1'b0;
                s_d.pend   = 1'b1;
            end
        end
        // stopped clock: load at once; running: wait for load point
        if (s_q.pend & (clk_off_i | load_point_i)) begin
            s_d.val  = s_q.buf_v;
            s_d.pend = 1'b0;
        end
        if (edge_hit) begin
            s_d.val = counter_i;
        end
        if (center_align_select_i) begin
            if (pwm_any) begin
                if (center_aligned_pwm_off) begin
                    s_d.pin = edge_level_sel_a_i;
                end else if (match) begin
                    // a match at the top turn is full width
                    s_d.pin = (count_up_i & !overflow_i) ?
                              edge_level_sel_a_i : !edge_level_sel_a_i;
                end else if (bottom) begin
                    // value above modulus never matches: active from center
                    s_d.pin = !edge_level_sel_a_i;
                end
            end
        end else if (channel_mode_sel_b_i) begin
            if (overflow_i) begin
                s_d.pin = !edge_level_sel_a_i;
            end
            if (arrive) begin
                s_d.pin = edge_level_sel_a_i;
            end
            // zero value: pin held inactive every cycle, overriding the overflow set
            if (s_q.val == tpc_pkg::VAL_RST) begin
                s_d.pin = edge_level_sel_a_i;
            end
        end else if (oc_mode & match) begin
            case ({edge_level_sel_b_i, edge_level_sel_a_i})
                2'h1:    s_d.pin = !s_q.pin;
                2'h2:    s_d.pin = 1'b0;
                2'h3:    s_d.pin = 1'b1;
                default: s_d.pin = s_q.pin;
            endcase
        end
        // set wins over clear
        if (flag_clear_i) begin
            s_d.flag = 1'b0;
        end
        if (edge_hit | (match & !cap_mode)) begin
            s_d.flag = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign channel_value_o      = s_q.val;
    assign channel_event_flag_o = s_q.flag;
    assign channel_irq_o        = s_q.flag & channel_irq_enable_i;
    assign pin_o                = s_q.pin;
    // pins stay released in capture mode and with edge bits and channel_mode_sel_b_i clear
    assign pin_oe_o = !cap_mode &
                      (edge_level_sel_a_i | edge_level_sel_b_i |
                       channel_mode_sel_b_i);

    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_flag_set: assert property (
        (match & !cap_mode) |=> s_q.flag)
        else $error("flag not set on match");
    a_flag_clr: assert property (
        (flag_clear_i & !edge_hit & !match) |=> !s_q.flag)
        else $error("flag not cleared");
    a_wr_cancel: assert property (
        csc_write_i |=> !s_q.pend && !s_q.got_lo)
        else $error("write not cancelled");
    a_off_load: assert property (
        (clk_off_i & s_q.pend & !edge_hit) |=> s_q.val == $past(s_q.buf_v))
        else $error("value not loaded with clock off");
    a_zero_duty: assert property (
        (!center_align_select_i & channel_mode_sel_b_i & s_q.val == 16'h0000)
        |=> s_q.pin == $past(edge_level_sel_a_i))
        else $error("zero duty pin active");
    a_edge_end: assert property (
        (!center_align_select_i & channel_mode_sel_b_i & arrive)
        |=> s_q.pin == $past(edge_level_sel_a_i))
        else $error("pulse not ended at compare");
    c_epwm_match: cover property (match & channel_mode_sel_b_i);
    c_center_aligned_pwm_down: cover property (match & center_align_select_i & !count_up_i);
    c_capture: cover property (edge_hit);
endmodule // tpc_channel

// [test/tpc_timer_bench.sv]
`timescale 1ns/100ps
module tpc_timer_bench;
    localparam int NCH = 2;
    logic            clk_i   = 1'b0;
    logic            rst_b_i = 1'b0;
    logic [1:0]      clk_src = 2'h0;
    logic            fix_en  = 1'b0;
    logic            ext_clk = 1'b0;
    logic            center  = 1'b0;
    logic            ov_ie   = 1'b0;
    logic            tsc_wr  = 1'b0;
    logic            mod_lo  = 1'b0;
    logic            mod_hi  = 1'b0;
    logic            cnt_wr  = 1'b0;
    logic            ov_clr  = 1'b0;
    logic [7:0]      wdat    = 8'h00;
    logic [NCH-1:0]  msa = '0, msb = '0, ela = '0, elb = '0, chie = '0;
    logic [NCH-1:0]  csc = '0, vlo = '0, vhi = '0, fclr = '0, cap = '0;
    logic [15:0]     cnt, modv;
    logic            ovf, ovirq;
    logic [NCH-1:0]  chf, chirq, pin, pinoe;
    logic [31:0]     chval;
    logic [31:0]     seed = 32'hecc3fe7a;
    int              n_mismatch = 0;
    int              n_tests = 0;

    always #10 clk_i = ~clk_i;

    tpc_timer #(.NUM_CH(NCH)) DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .clock_source_select_i(clk_src),
        .fixed_clk_en_i(fix_en), .ext_clk_i(ext_clk),
        .center_align_select_i(center), .overflow_irq_enable_i(ov_ie),
        .tsc_write_i(tsc_wr), .mod_lo_wr_i(mod_lo), .mod_hi_wr_i(mod_hi),
        .cnt_write_i(cnt_wr), .wr_data_i(wdat), .overflow_clear_i(ov_clr),
        .channel_mode_sel_a_i(msa), .channel_mode_sel_b_i(msb),
        .edge_level_sel_a_i(ela), .edge_level_sel_b_i(elb),
        .channel_irq_enable_i(chie), .csc_write_i(csc), .val_lo_wr_i(vlo),
        .val_hi_wr_i(vhi), .flag_clear_i(fclr), .capture_pin_i(cap),
        .counter_value_o(cnt), .modulus_value_o(modv),
        .overflow_flag_o(ovf), .overflow_irq_o(ovirq),
        .channel_event_flag_o(chf), .channel_irq_o(chirq), .pin_o(pin),
        .pin_oe_o(pinoe), .channel_value_o(chval));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic wr_mod(input logic [15:0] v);
        wdat = v[7:0]; mod_lo = 1'b1; step(1);
        wdat = v[15:8]; mod_lo = 1'b0; mod_hi = 1'b1; step(1);
        mod_hi = 1'b0;
    endtask

    task automatic wr_val(input int ch, input logic [15:0] v);
        wdat = v[7:0]; vlo[ch] = 1'b1; step(1);
        wdat = v[15:8]; vlo[ch] = 1'b0; vhi[ch] = 1'b1; step(1);
        vhi[ch] = 1'b0;
    endtask

    task automatic restart;
        cnt_wr = 1'b1; step(1); cnt_wr = 1'b0;
    endtask

    // bounded wait for a counter value, a hang ends the run
    task automatic wait_cnt(input logic [15:0] t);
        int k;
        k = 0;
        while (cnt !== t && k < 2000) begin
            step(1); k++;
        end
        if (k >= 2000) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    // cycles at high level over np whole periods
    function automatic int exp_hi(input logic ctr, input int m,
                                  input logic [15:0] v, input logic pol,
                                  input int np);
        int per, act;
        per = ctr ? 2 * m : m + 1;
        if (v == 16'h0000 || (ctr && v[15])) act = 0;
        else if (v > m) act = per;
        else act = ctr ? 2 * v : v;
        return pol ? np * (per - act) : np * act;
    endfunction

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int m, per, h0, h1, mx, nz;
        logic [15:0] v0, v1, c;
        logic ctr;
        repeat (6) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        check({ovf, chf, pin, pinoe}, 32'h0);
        check({cnt, modv}, 32'h0);
        check(chval, 32'h0);
        // control writes drop a half-done pair
        wdat = 8'h21; mod_lo = 1'b1; vlo[0] = 1'b1; step(1);
        mod_lo = 1'b0; vlo[0] = 1'b0; tsc_wr = 1'b1; csc[0] = 1'b1; step(1);
        tsc_wr = 1'b0; csc[0] = 1'b0; mod_hi = 1'b1; vhi[0] = 1'b1; step(1);
        mod_hi = 1'b0; vhi[0] = 1'b0; step(3);
        check({modv, chval[15:0]}, 32'h0);
        // drop the lone high bytes before the rounds start
        tsc_wr = 1'b1; csc[0] = 1'b1; step(1);
        tsc_wr = 1'b0; csc[0] = 1'b0;
        for (int r = 0; r < 6; r++) begin
            seed = lfsr(seed);
            ctr = (r >= 3);
            m = 8 + seed[4:0];
            per = ctr ? 2 * m : m + 1;
            v0 = (r == 0) ? 16'h0 : (r == 1) ? 16'(m + 1)
                 : 16'(seed[15:8] % m + 1);
            v1 = (r == 3) ? {8'h80, seed[7:0]} : (r == 4) ? 16'(m + 3)
                 : 16'(seed[23:16] % m + 1);
            clk_src = 2'h0; center = ctr; msb = ctr ? '0 : '1; msa = '0;
            elb = '1; ela = seed[28:27]; chie = seed[25:24]; ov_ie = seed[26];
            wr_mod(16'(m)); wr_val(0, v0); wr_val(1, v1); step(2);
            check(modv, m);
            check(chval, {v1, v0});
            clk_src = 2'h1; restart(); step(per);
            fclr = '1; ov_clr = 1'b1; step(1); fclr = '0; ov_clr = 1'b0;
            step(per - 1);
            h0 = 0; h1 = 0; mx = 0; nz = 0;
            repeat (2 * per) begin
                step(1);
                h0 += (pin[0] === 1'b1); h1 += (pin[1] === 1'b1);
                nz += (cnt === 16'h0); mx = (cnt > mx) ? int'(cnt) : mx;
            end
            check(h0, exp_hi(ctr, m, v0, ela[0], 2));
            check(h1, exp_hi(ctr, m, v1, ela[1], 2));
            check(mx, m);
            check(nz, 2);
            check(pinoe, 32'h3);
            clk_src = 2'h0; step(1);
            c = cnt; step(5);
            check(cnt, c);
            check({ovf, ovirq}, {1'b1, ov_ie});
            check(chf, {v1 <= m, v0 <= m});
            check(chirq, {v1 <= m, v0 <= m} & chie);
        end
        // buffered value waits for the step to the modulus
        center = 1'b0; msb = '1; clk_src = 2'h1; restart();
        wr_val(0, 16'h0003);
        wait_cnt(16'(m - 1));
        check(chval[15:0], v0);
        step(1);
        check({cnt, chval[15:0]}, {16'(m), 16'h0003});
        // clear in the same cycle as a new overflow
        ov_clr = 1'b1; step(1); ov_clr = 1'b0;
        check(ovf, 1'b1);
        clk_src = 2'h0; ov_clr = 1'b1; step(1); ov_clr = 1'b0;
        check(ovf, 1'b0);
        // capture of a frozen count on a rising pin
        msa = '0; msb = '0; ela = 2'h2; elb = 2'h0; fclr = '1; step(1);
        fclr = '0; cap[1] = 1'b1; step(5);
        check({chf[1], chval[31:16]}, {1'b1, 16'h0000});
        // fixed and external count sources
        msb = '1; wr_mod(16'h0100); restart(); clk_src = 2'h2;
        repeat (5) begin
            fix_en = 1'b1; step(1); fix_en = 1'b0; step(1);
        end
        check(cnt, 16'h0005);
        restart(); clk_src = 2'h3;
        repeat (4) begin
            ext_clk = 1'b1; step(3); ext_clk = 1'b0; step(3);
        end
        step(4);
        check(cnt, 16'h0004);
        give_verdict();
    end
endmodule // tpc_timer_bench
